// *** logic/vic_controller.sv ***
// Vectored interrupt unit: pending, ranking, acknowledge and end of service
`timescale 1ns/1ns
module vic_controller (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Interrupt sources
  input  wire logic [vic_pkg::NUM_SRC-1:0] src_in,
  // Normal request vector interface
  output logic                             irq_req,
  output logic [vic_pkg::SRC_W-1:0]        irq_vec,
  input  wire logic                        irq_core_ack,
  // Fast request vector interface
  output logic                             fiq_req,
  output logic [vic_pkg::SRC_W-1:0]        fiq_vec,
  input  wire logic                        fiq_core_ack,
  // Register access port
  input  wire vic_pkg::vic_sel_t           reg_sel,
  input  wire logic [vic_pkg::SRC_W-1:0]   reg_idx,
  input  wire logic                        reg_rd,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_debug,
  input  wire logic [vic_pkg::WORD_W-1:0]  reg_wdata,
  output logic [vic_pkg::WORD_W-1:0]       reg_rdata
);
  import vic_pkg::*;

  logic [NUM_SRC-1:0] sw_pend_reg;
  logic [NUM_SRC-1:0] enable_reg;
  logic [NUM_SRC-1:0] fast_reg;
  vic_prio_t          prio_reg;
  logic [NUM_LVL-1:0] irq_act_reg;
  logic [NUM_LVL-1:0] fiq_act_reg;
  logic [NUM_LVL-1:0] irq_act_next;
  logic [NUM_LVL-1:0] fiq_act_next;
  logic               irq_req_reg;
  logic               fiq_req_reg;
  logic [SRC_W-1:0]   irq_id_reg;
  logic [SRC_W-1:0]   fiq_id_reg;
  logic [LVL_W-1:0]   irq_lvl_reg;
  logic [LVL_W-1:0]   fiq_lvl_reg;
  logic [NUM_SRC-1:0] pend;
  logic [NUM_SRC-1:0] irq_cand;
  logic [NUM_SRC-1:0] fiq_cand;
  logic               irq_win;
  logic               fiq_win;
  logic [SRC_W-1:0]   irq_win_id;
  logic [SRC_W-1:0]   fiq_win_id;
  logic [LVL_W-1:0]   irq_win_lvl;
  logic [LVL_W-1:0]   fiq_win_lvl;
  logic               func_rd;
  logic               irq_ack;
  logic               fiq_ack;
  logic               irq_eoi;
  logic               fiq_eoi;
  logic [8:0]         word_base;

  //////////////////////////////////////////////////////////////////////////
  // Pending and candidate sets

  assign pend      = src_in | sw_pend_reg;
  assign irq_cand  = pend & enable_reg & ~fast_reg;
  assign fiq_cand  = pend & enable_reg & fast_reg;
  assign word_base = {reg_idx[WORD_SEL-1:0], 5'h00};

  //////////////////////////////////////////////////////////////////////////
  // Acknowledge and end of service

  // Debug reads are excluded so a debugger never acknowledges
  assign func_rd = reg_rd && !reg_debug;
  assign irq_ack = irq_req_reg &&
                   ((func_rd && reg_sel == VIC_SEL_IRQVEC) ||
                    irq_core_ack);
  assign fiq_ack = fiq_req_reg &&
                   ((func_rd && reg_sel == VIC_SEL_FIQVEC) ||
                    fiq_core_ack);
  assign irq_eoi = reg_wr && reg_sel == VIC_SEL_IRQVEC;
  assign fiq_eoi = reg_wr && reg_sel == VIC_SEL_FIQVEC;

  // End pops the innermost level; a same-cycle ack still lands
  always_comb begin
    irq_act_next = irq_act_reg;
    fiq_act_next = fiq_act_reg;
    if (irq_eoi) begin
      irq_act_next = irq_act_reg & (irq_act_reg - 16'h0001);
    end
    if (fiq_eoi) begin
      fiq_act_next = fiq_act_reg & (fiq_act_reg - 16'h0001);
    end
    if (irq_ack) begin
      irq_act_next = irq_act_next | (16'h0001 << irq_lvl_reg);
    end
    if (fiq_ack) begin
      fiq_act_next = fiq_act_next | (16'h0001 << fiq_lvl_reg);
    end
  end

  // Nothing depends on the core having run the handler
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_act_reg <= ACT_RST;
      fiq_act_reg <= ACT_RST;
    end else begin
      irq_act_reg <= irq_act_next;
      fiq_act_reg <= fiq_act_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Ranking against the next service ceiling

  // Next ceiling used so an acked source is not offered a second time
  vic_arbiter u_irq_arb (
    .req   (irq_cand),
    .prio  (prio_reg),
    .ceil  (vic_ceil(irq_act_next)),
    .valid (irq_win),
    .id    (irq_win_id),
    .lvl   (irq_win_lvl)
  );

  vic_arbiter u_fiq_arb (
    .req   (fiq_cand),
    .prio  (prio_reg),
    .ceil  (vic_ceil(fiq_act_next)),
    .valid (fiq_win),
    .id    (fiq_win_id),
    .lvl   (fiq_win_lvl)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_req_reg <= 1'b0;
      irq_id_reg  <= '0;
      irq_lvl_reg <= '0;
      fiq_req_reg <= 1'b0;
      fiq_id_reg  <= '0;
      fiq_lvl_reg <= '0;
    end else begin
      irq_req_reg <= irq_win;
      irq_id_reg  <= irq_win_id;
      irq_lvl_reg <= irq_win_lvl;
      fiq_req_reg <= fiq_win;
      fiq_id_reg  <= fiq_win_id;
      fiq_lvl_reg <= fiq_win_lvl;
    end
  end

  assign irq_req = irq_req_reg;
  assign irq_vec = irq_id_reg;
  assign fiq_req = fiq_req_reg;
  assign fiq_vec = fiq_id_reg;

  //////////////////////////////////////////////////////////////////////////
  // Configuration and software pending writes

  always_ff @(posedge clk) begin
    if (rst) begin
      sw_pend_reg <= '0;
    end else if (reg_wr && reg_sel == VIC_SEL_RAW) begin
      sw_pend_reg[word_base +: WORD_W] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      enable_reg <= ENABLE_RST;
      fast_reg   <= FAST_RST;
    end else if (reg_wr && reg_sel == VIC_SEL_ENABLE) begin
      enable_reg[word_base +: WORD_W] <= reg_wdata;
    end else if (reg_wr && reg_sel == VIC_SEL_FAST) begin
      fast_reg[word_base +: WORD_W] <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prio_reg <= {NUM_SRC{PRIO_RST}};
    end else if (reg_wr && reg_sel == VIC_SEL_PRIO) begin
      prio_reg[reg_idx] <= reg_wdata[LVL_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data; debug and functional reads see the same contents

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= RDATA_RST;
    end else if (reg_rd) begin
      case (reg_sel)
        VIC_SEL_RAW: begin
          reg_rdata <= pend[word_base +: WORD_W];
        end
        VIC_SEL_ENABLE: begin
          reg_rdata <= enable_reg[word_base +: WORD_W];
        end
        VIC_SEL_FAST: begin
          reg_rdata <= fast_reg[word_base +: WORD_W];
        end
        VIC_SEL_PRIO: begin
          reg_rdata <= {28'h0000000, prio_reg[reg_idx]};
        end
        VIC_SEL_IRQVEC: begin
          reg_rdata <= {irq_req_reg, 22'h000000, irq_id_reg};
        end
        VIC_SEL_FIQVEC: begin
          reg_rdata <= {fiq_req_reg, 22'h000000, fiq_id_reg};
        end
        VIC_SEL_ACTIVE: begin
          reg_rdata <= {fiq_act_reg, irq_act_reg};
        end
        default: begin
          reg_rdata <= RDATA_RST;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence reg_ack_s;
    reg_rd && !reg_debug && reg_sel == VIC_SEL_IRQVEC && irq_req_reg &&
    !irq_core_ack && !reg_wr;
  endsequence

  sequence reg_eoi_s;
    reg_wr && reg_sel == VIC_SEL_IRQVEC && !irq_core_ack && !reg_rd;
  endsequence

  vec_read_ack_a: assert property (
    reg_ack_s |=> irq_act_reg[$past(irq_lvl_reg)])
    else $error("functional vector read did not acknowledge");

  func_only_a: assert property (
    reg_rd && !reg_wr && !irq_core_ack && !fiq_core_ack &&
    reg_sel != VIC_SEL_IRQVEC && reg_sel != VIC_SEL_FIQVEC
    |=> $stable(irq_act_reg) && $stable(fiq_act_reg))
    else $error("plain read changed service state");

  debug_read_a: assert property (
    reg_rd && reg_debug && !reg_wr && !irq_core_ack && !fiq_core_ack
    |=> $stable(irq_act_reg) && $stable(fiq_act_reg))
    else $error("debug read changed service state");

  raw_set_a: assert property (
    reg_wr && reg_sel == VIC_SEL_RAW
    |=> sw_pend_reg[$past(word_base) +: WORD_W] == $past(reg_wdata))
    else $error("raw write did not take effect");

  raw_clear_a: assert property (
    reg_wr && reg_sel == VIC_SEL_RAW && reg_wdata == 32'h0000_0000
    ##1 src_in[$past(word_base) +: WORD_W] == 32'h0000_0000
    |-> pend[$past(word_base) +: WORD_W] == 32'h0000_0000)
    else $error("raw clear left a pending bit");

  eoi_pop_a: assert property (
    reg_eoi_s |=> irq_act_reg == ($past(irq_act_reg) &
                                  ($past(irq_act_reg) - 16'h0001)))
    else $error("end of service did not pop one level");

  core_ack_a: assert property (
    fiq_core_ack && fiq_req_reg |=> fiq_act_reg[$past(fiq_lvl_reg)])
    else $error("fast vector ack not recorded");

  reg_handshake_a: assert property (
    reg_ack_s ##1 reg_eoi_s |=> irq_act_reg == $past(irq_act_reg, 2))
    else $error("register handshake did not restore context");

  raw_read_a: assert property (
    reg_rd && reg_sel == VIC_SEL_RAW
    |=> reg_rdata == $past(pend[word_base +: WORD_W]))
    else $error("raw status read mismatch");

  preempt_lvl_a: assert property (
    irq_req_reg |-> {1'b0, irq_lvl_reg} < vic_ceil(irq_act_reg))
    else $error("request not above level in service");

  fiq_read_ack_a: assert property (
    reg_rd && !reg_debug && reg_sel == VIC_SEL_FIQVEC && fiq_req_reg &&
    !reg_wr |=> fiq_act_reg[$past(fiq_lvl_reg)])
    else $error("functional fast vector read did not acknowledge");

  debug_vec_a: assert property (
    reg_rd && reg_debug && reg_sel == VIC_SEL_IRQVEC
    |=> reg_rdata == {$past(irq_req_reg), 22'h000000, $past(irq_id_reg)})
    else $error("debug vector read mismatch");

  fiq_eoi_pop_a: assert property (
    reg_wr && reg_sel == VIC_SEL_FIQVEC && !fiq_core_ack && !reg_rd
    |=> fiq_act_reg == ($past(fiq_act_reg) &
                        ($past(fiq_act_reg) - 16'h0001)))
    else $error("end of fast service did not pop one level");

  irq_core_ack_a: assert property (
    irq_core_ack && irq_req_reg |=> irq_act_reg[$past(irq_lvl_reg)])
    else $error("normal vector ack not recorded");

  fiq_preempt_a: assert property (
    fiq_req_reg |-> {1'b0, fiq_lvl_reg} < vic_ceil(fiq_act_reg))
    else $error("fast request not above level in service");

endmodule

// *** logic/vic_pkg.sv ***
// Constants, types and helpers shared by the vectored interrupt unit
// Contract
// - Functional read of irq_vector_register acknowledges the reported interrupt.
// - Only functional reads have side effects on controller state.
// - Debug reads return contents and leave all state untouched.
// - 512 source inputs, each with priority, usable as hardware or software.
// - Sixteen levels, zero is highest, above one through fifteen.
// - Writing one to a raw status/set bit makes that source pending.
// - Writing zero to a raw status/set bit removes the software pending.
// - Any write to irq_vector_register ends service, restoring prior context.
// - Serve by vector handoff or registers, both for fast and normal.
// - Register-only acknowledge and end complete even when core masked it.
// - Raw status is readable so handlers see higher pending work.
package vic_pkg;

  localparam int NUM_SRC   = 512;
  localparam int SRC_W     = 9;
  localparam int NUM_LVL   = 16;
  localparam int LVL_W     = 4;
  localparam int CEIL_W    = 5;
  localparam int WORD_W    = 32;
  localparam int WORD_SEL  = 4;

  // Ceiling value meaning nothing is in service
  localparam logic [CEIL_W-1:0]  CEIL_IDLE   = 5'h10;
  localparam logic [LVL_W-1:0]   PRIO_RST    = 4'hf;
  localparam logic [NUM_SRC-1:0] ENABLE_RST  = '0;
  localparam logic [NUM_SRC-1:0] FAST_RST    = '0;
  localparam logic [NUM_LVL-1:0] ACT_RST     = 16'h0000;
  localparam logic [WORD_W-1:0]  RDATA_RST   = 32'h0000_0000;
  localparam int                 VEC_PAD_W   = 22;

  typedef logic [NUM_SRC-1:0][LVL_W-1:0] vic_prio_t;

  // Register selector of the access port
  typedef enum logic [2:0] {
    VIC_SEL_RAW    = 3'h0,
    VIC_SEL_ENABLE = 3'h1,
    VIC_SEL_PRIO   = 3'h2,
    VIC_SEL_FAST   = 3'h3,
    VIC_SEL_IRQVEC = 3'h4,
    VIC_SEL_FIQVEC = 3'h5,
    VIC_SEL_ACTIVE = 3'h6
  } vic_sel_t;

  // Level currently in service: lowest set bit, or idle
  function automatic logic [CEIL_W-1:0] vic_ceil(
    input logic [NUM_LVL-1:0] act
  );
    logic [CEIL_W-1:0] c;
    c = CEIL_IDLE;
    for (int i = NUM_LVL - 1; i >= 0; i--) begin
      if (act[i]) begin
        c = CEIL_W'(i);
      end
    end
    return c;
  endfunction

endpackage

// *** logic/vic_arbiter.sv ***
// Priority arbiter picking the best source below a service ceiling
`timescale 1ns/1ns
module vic_arbiter (
  // Candidates
  input  wire logic [vic_pkg::NUM_SRC-1:0] req,
  input  wire vic_pkg::vic_prio_t          prio,
  input  wire logic [vic_pkg::CEIL_W-1:0]  ceil,
  // Winner
  output logic                             valid,
  output logic [vic_pkg::SRC_W-1:0]        id,
  output logic [vic_pkg::LVL_W-1:0]        lvl
);
  import vic_pkg::*;

  logic [CEIL_W-1:0] best;

  // Strict compare keeps the lower index on ties
  always_comb begin
    best  = ceil;
    valid = 1'b0;
    id    = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req[i] && ({1'b0, prio[i]} < best)) begin
        best  = {1'b0, prio[i]};
        id    = SRC_W'(i);
        valid = 1'b1;
      end
    end
    lvl = best[LVL_W-1:0];
  end

endmodule

// *** testbench/vic_core_model.sv ***
// Processor core model taking one vectored request channel
`timescale 1ns/1ns
module vic_core_model (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Request channel
  input  wire logic                      req,
  input  wire logic [vic_pkg::SRC_W-1:0] vec,
  output logic                           ack,
  // Behaviour and record
  input  wire logic                      accept,
  input  wire logic [3:0]                lag,
  output logic [vic_pkg::SRC_W-1:0]      last_vec,
  output int                             takes
);
  logic [3:0] wait_reg;

  ////////////////////////////////////////////////////////////////////////
  // Waits lag cycles, then a one-cycle ack; restarts after every ack
  always @(negedge clk) begin
    if (rst) begin
      ack      <= 1'b0;
      wait_reg <= 4'h0;
      takes    <= 0;
      last_vec <= '0;
    end else if (ack || !(accept && req)) begin
      ack      <= 1'b0;
      wait_reg <= 4'h0;
    end else if (wait_reg == lag) begin
      ack      <= 1'b1;
      last_vec <= vec;
      takes    <= takes + 1;
    end else begin
      ack      <= 1'b0;
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ns
module tb_top;
  import vic_pkg::*;
  logic               clk, rst, rd_d, irq_req, fiq_req, irq_ack, fiq_ack;
  logic               reg_rd, reg_wr, reg_debug;
  logic [NUM_SRC-1:0] src_in, en_m, fa_m;
  logic [SRC_W-1:0]   irq_vec, fiq_vec, reg_idx, lv_i, lv_f;
  vic_sel_t           reg_sel;
  logic [WORD_W-1:0]  reg_wdata, reg_rdata;
  logic [WORD_W-1:0]  exp_q[$];
  logic [LVL_W-1:0]   plv[NUM_SRC];
  logic [31:0]        seed;
  logic [1:0]         acc;
  logic [3:0]         lag;
  int                 num_errors, cmp_count, tk_i, tk_f, tk0;

  vic_controller dut (.clk(clk), .rst(rst), .src_in(src_in),
    .irq_req(irq_req), .irq_vec(irq_vec), .irq_core_ack(irq_ack),
    .fiq_req(fiq_req), .fiq_vec(fiq_vec), .fiq_core_ack(fiq_ack),
    .reg_sel(reg_sel), .reg_idx(reg_idx), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_debug(reg_debug), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  vic_core_model core_i (.clk(clk), .rst(rst), .req(irq_req),
    .vec(irq_vec), .ack(irq_ack), .accept(acc[0]), .lag(lag),
    .last_vec(lv_i), .takes(tk_i));
  vic_core_model core_f (.clk(clk), .rst(rst), .req(fiq_req),
    .vec(fiq_vec), .ack(fiq_ack), .accept(acc[1]), .lag(lag),
    .last_vec(lv_f), .takes(tk_f));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, e);
    cmp_count++;
    if (seen !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, seen);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  function automatic logic [31:0] vw(input int id);
    return {1'b1, {VEC_PAD_W{1'b0}}, SRC_W'(id)};
  endfunction

  function automatic logic cond(input int k);
    case (k)
      0: return irq_req === 1'b1;
      1: return fiq_req === 1'b1;
      2: return tk_i != tk0;
      default: return tk_f != tk0;
    endcase
  endfunction

  task automatic wait_on(input int k);
    int n;
    n = 0;
    while (!cond(k) && n < 60) begin
      @(negedge clk);
      n++;
    end
    if (!cond(k)) begin
      num_errors++;
      conclude();
    end
  endtask

  // Strobe for exactly one edge; next access starts one edge later
  task automatic acc_reg(input logic w, input vic_sel_t s, input int idx,
                         input logic [31:0] d, input logic dbg);
    @(negedge clk);
    reg_sel = s;
    reg_idx = SRC_W'(idx);
    reg_wdata = d;
    reg_debug = dbg;
    reg_rd = !w;
    reg_wr = w;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input vic_sel_t s, input int idx, input logic dbg,
                    input logic [31:0] e);
    exp_q.push_back(e);
    acc_reg(1'b0, s, idx, 32'h0, dbg);
  endtask

  task automatic wr(input vic_sel_t s, input int idx, input logic [31:0] d);
    acc_reg(1'b1, s, idx, d, 1'b0);
  endtask

  task automatic arm(input int id, input logic [3:0] l, input logic f);
    plv[id] = l;
    en_m[id] = 1'b1;
    fa_m[id] = f;
    wr(VIC_SEL_PRIO, id, 32'(l));
    wr(VIC_SEL_ENABLE, id / 32, en_m[id / 32 * 32 +: 32]);
    wr(VIC_SEL_FAST, id / 32, fa_m[id / 32 * 32 +: 32]);
  endtask

  task automatic do_reset();
    rst = 1'b1;
    acc = 2'b00;
    src_in = '0;
    en_m = '0;
    fa_m = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
  endtask

  // Read results land one cycle after the strobe
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) begin
    if (rd_d) begin
      check("reg_rdata", reg_rdata, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [NUM_SRC-1:0] sv;
    int best;
    reg_sel = VIC_SEL_RAW;
    reg_idx = '0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_debug = 1'b0;
    reg_wdata = '0;
    lag = 4'h2;
    seed = 32'hca2536d2;
    num_errors = 0;
    cmp_count = 0;
    do_reset();
    rd(VIC_SEL_PRIO, 3, 1'b0, 32'(PRIO_RST));
    rd(VIC_SEL_ENABLE, 0, 1'b0, 32'h0);
    rd(vic_sel_t'(3'h7), 0, 1'b0, 32'h0);
    check("irq_req", irq_req, 32'h0);
    check("fiq_req", fiq_req, 32'h0);
    $display("reset test done");
    // Register servicing with the core masked, dummy at level six
    arm(300, 4'h6, 1'b0);
    src_in[300] = 1'b1;
    wait_on(0);
    rd(VIC_SEL_IRQVEC, 0, 1'b0, vw(300));
    rd(VIC_SEL_RAW, 9, 1'b1, 32'h1000);
    arm(7, 4'h0, 1'b0);
    wr(VIC_SEL_RAW, 0, 32'h80);
    wait_on(0);
    rd(VIC_SEL_RAW, 0, 1'b1, 32'h80);
    rd(VIC_SEL_IRQVEC, 0, 1'b1, vw(7));
    rd(VIC_SEL_ACTIVE, 0, 1'b1, 32'h40);
    check("irq_req", irq_req, 32'h1);
    rd(VIC_SEL_IRQVEC, 0, 1'b0, vw(7));
    rd(VIC_SEL_ACTIVE, 0, 1'b0, 32'h41);
    wr(VIC_SEL_RAW, 0, 32'h0);
    rd(VIC_SEL_RAW, 0, 1'b0, 32'h0);
    wr(VIC_SEL_IRQVEC, 0, 32'h0);
    rd(VIC_SEL_ACTIVE, 0, 1'b0, 32'h40);
    $display("register servicing test done");
    // Random sources and levels, applied together
    for (int r = 0; r < 3; r++) begin
      do_reset();
      sv = '0;
      for (int k = 0; k < 4; k++) begin
        seed = xs(seed);
        arm(int'(seed[8:0]), seed[12:9], 1'b0);
        sv[seed[8:0]] = 1'b1;
      end
      src_in = sv;
      best = 0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (sv[i] && (!sv[best] || plv[i] <= plv[best])) begin
          best = i;
        end
      end
      wait_on(0);
      check("irq_vec", irq_vec, 32'(best));
      rd(VIC_SEL_IRQVEC, 0, 1'b1, vw(best));
    end
    $display("ranking test done");
    // Vector handoff, preemption by the same source twice
    do_reset();
    acc = 2'b01;
    arm(20, 4'h5, 1'b0);
    arm(21, 4'h2, 1'b0);
    tk0 = tk_i;
    src_in[20] = 1'b1;
    wait_on(2);
    tk0 = tk_i;
    src_in[21] = 1'b1;
    wait_on(2);
    check("core vector", lv_i, 32'd21);
    rd(VIC_SEL_ACTIVE, 0, 1'b0, 32'h24);
    src_in[21] = 1'b0;
    wr(VIC_SEL_IRQVEC, 0, 32'h0);
    rd(VIC_SEL_ACTIVE, 0, 1'b0, 32'h20);
    lag = 4'h7;
    tk0 = tk_i;
    src_in[21] = 1'b1;
    wait_on(2);
    check("core vector", lv_i, 32'd21);
    rd(VIC_SEL_ACTIVE, 0, 1'b0, 32'h24);
    $display("preemption test done");
    // Fast requests, register way then vector way
    for (int m = 0; m < 2; m++) begin
      do_reset();
      acc = m ? 2'b10 : 2'b00;
      arm(40, 4'h3, 1'b1);
      rd(VIC_SEL_FAST, 1, 1'b1, 32'h100);
      tk0 = tk_f;
      wr(VIC_SEL_RAW, 1, 32'h100);
      if (m) begin
        wait_on(3);
        check("core vector", lv_f, 32'd40);
      end else begin
        wait_on(1);
        check("fiq_vec", fiq_vec, 32'd40);
        rd(VIC_SEL_FIQVEC, 0, 1'b0, vw(40));
      end
      check("irq_req", irq_req, 32'h0);
      rd(VIC_SEL_ACTIVE, 0, 1'b0, 32'h80000);
      wr(VIC_SEL_FIQVEC, 0, 32'h0);
      rd(VIC_SEL_ACTIVE, 0, 1'b0, 32'h0);
    end
    $display("fast request test done");
    repeat (3) @(negedge clk);
    conclude();
  end
endmodule
